/* psfb_status_bank.sv */
// status flag bank top: per-page input, temperature and communication status bytes
module psfb_status_bank (
    input  wire logic                                          sys_clk,
    input  wire logic                                          reset_n,
    input  wire psfb_pkg::psfb_host_req_s                      host_req,
    input  wire psfb_pkg::psfb_events_s [psfb_pkg::NUM_PAGES-1:0] events,
    input  wire psfb_pkg::psfb_mask_s   [psfb_pkg::NUM_PAGES-1:0] alert_masks,
    input  wire logic [psfb_pkg::NUM_PAGES-1:0]                power_input_rail_low,
    input  wire logic [psfb_pkg::NUM_PAGES-1:0]                internal_five_volt_rail_low,
    input  wire logic [psfb_pkg::NUM_PAGES-1:0]                is_loop_follower,
    output      logic [7:0]                                    rd_data_r,
    output      logic                                          rd_valid_r,
    output      logic                                          bad_command_r,
    output      logic [psfb_pkg::NUM_PAGES-1:0]                cml_summary_r,
    output      logic [psfb_pkg::NUM_PAGES-1:0]                alert_request_r
);
    localparam int NP = psfb_pkg::NUM_PAGES;

    logic [7:0] in_flags   [NP];
    logic [7:0] tmp_flags  [NP];
    logic [7:0] cml_flags  [NP];
    logic [NP-1:0] rail_low_s1_r;
    logic [NP-1:0] rail_low_s2_r;
    logic [NP-1:0] five_low_s1_r;
    logic [NP-1:0] five_low_s2_r;
    logic [NP-1:0] input_below_turn_on_r;
    logic [NP-1:0] uvw_armed_r;
    logic [NP-1:0] alert_nxt;
    logic          wr_in;
    logic          wr_tmp;
    logic          wr_cml;
    logic          cmd_known;

    always_comb begin
        wr_in     = host_req.wr_valid && host_req.command == psfb_pkg::CMD_INPUT_STATUS;
        wr_tmp    = host_req.wr_valid && host_req.command == psfb_pkg::CMD_TEMP_STATUS;
        wr_cml    = host_req.wr_valid && host_req.command == psfb_pkg::CMD_CML_STATUS;
        cmd_known = host_req.command == psfb_pkg::CMD_INPUT_STATUS
                 || host_req.command == psfb_pkg::CMD_TEMP_STATUS
                 || host_req.command == psfb_pkg::CMD_CML_STATUS;
    end

    // rail levels come from analog comparators, so resynchronise them
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rail_low_s1_r <= '1;
            rail_low_s2_r <= '1;
            five_low_s1_r <= '1;
            five_low_s2_r <= '1;
        end else begin
            rail_low_s1_r <= power_input_rail_low;
            rail_low_s2_r <= rail_low_s1_r;
            five_low_s1_r <= internal_five_volt_rail_low;
            five_low_s2_r <= five_low_s1_r;
        end
    end

    // live low-input indicator, not latched, ignores write-one and clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            input_below_turn_on_r <= {NP{psfb_pkg::LOW_IN_RESET}};
        end else begin
            input_below_turn_on_r <= rail_low_s2_r | five_low_s2_r;
        end
    end

    // warning arms once the input first climbs above turn-on; clear-faults does not disarm
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            uvw_armed_r <= '0;
        end else begin
            uvw_armed_r <= uvw_armed_r | ~rail_low_s2_r;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_page
            logic       sel;
            logic [7:0] in_set;
            logic [7:0] tmp_set;
            logic [7:0] cml_set;
            logic       follower_fault;
            logic       alert_page;

            always_comb begin
                sel = host_req.page == 1'(p);
                follower_fault = events[p].backchannel_fault && is_loop_follower[p];
                in_set = 8'h00;
                in_set[psfb_pkg::IN_OVF_BIT] = events[p].input_overvolt_fault;
                in_set[psfb_pkg::IN_UVW_BIT] = events[p].input_undervolt_warn
                                             && uvw_armed_r[p];
                tmp_set = 8'h00;
                tmp_set[psfb_pkg::TMP_OTF_BIT] = events[p].overtemp_fault;
                tmp_set[psfb_pkg::TMP_OTW_BIT] = events[p].overtemp_warn;
                cml_set = 8'h00;
                cml_set[psfb_pkg::CML_CMD_BIT]  = events[p].bad_command_flag
                    || (host_req.wr_valid || host_req.rd_valid) && !cmd_known && sel;
                cml_set[psfb_pkg::CML_DATA_BIT] = events[p].bad_payload_flag;
                cml_set[psfb_pkg::CML_PEC_BIT]  = events[p].pec_fail;
                cml_set[psfb_pkg::CML_MEM_BIT]  = events[p].memory_error;
                cml_set[psfb_pkg::CML_CORE_BIT] = events[p].logic_core_error;
                cml_set[psfb_pkg::CML_LINK_BIT] = events[p].link_error_flag
                                                || follower_fault;
            end

            psfb_flag_byte #(.LATCH_MASK(psfb_pkg::IN_LATCH_MASK)) u_in (
                .sys_clk    (sys_clk),
                .reset_n    (reset_n),
                .set_bits   (in_set),
                .clear_all  (host_req.clear_faults && sel),
                .write_one  (wr_in && sel),
                .write_data (host_req.data),
                .flags_r    (in_flags[p])
            );

            psfb_flag_byte #(.LATCH_MASK(psfb_pkg::TMP_LATCH_MASK)) u_tmp (
                .sys_clk    (sys_clk),
                .reset_n    (reset_n),
                .set_bits   (tmp_set),
                .clear_all  (host_req.clear_faults && sel),
                .write_one  (wr_tmp && sel),
                .write_data (host_req.data),
                .flags_r    (tmp_flags[p])
            );

            psfb_flag_byte #(.LATCH_MASK(psfb_pkg::CML_LATCH_MASK)) u_cml (
                .sys_clk    (sys_clk),
                .reset_n    (reset_n),
                .set_bits   (cml_set),
                .clear_all  (host_req.clear_faults && sel),
                .write_one  (wr_cml && sel),
                .write_data (host_req.data),
                .flags_r    (cml_flags[p])
            );

            // low-input bit 3 is left out: it is informational only
            always_comb begin
                alert_page = |(in_flags[p] & psfb_pkg::IN_LATCH_MASK
                               & ~alert_masks[p].input_mask)
                           || |(tmp_flags[p] & ~alert_masks[p].temp_mask)
                           || |(cml_flags[p] & ~alert_masks[p].cml_mask);
            end

            // one writer per page bit, so no process shares the alert vector
            assign alert_nxt[p] = alert_page;
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_request_r <= '0;
        end else begin
            alert_request_r <= alert_nxt;
        end
    end

    // summary follows the latched flags, so write-one clears drop it as well
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cml_summary_r <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                cml_summary_r[i] <= |cml_flags[i];
            end
        end
    end

    // read port: one byte per Read Byte, addressed page selects the copy
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r     <= 8'h00;
            rd_valid_r    <= 1'b0;
            bad_command_r <= 1'b0;
        end else begin
            rd_valid_r    <= host_req.rd_valid;
            bad_command_r <= (host_req.rd_valid || host_req.wr_valid) && !cmd_known;
            if (host_req.rd_valid) begin
                unique case (host_req.command)
                    psfb_pkg::CMD_INPUT_STATUS: begin
                        rd_data_r <= in_flags[host_req.page]
                                   | ({7'h00, input_below_turn_on_r[host_req.page]}
                                      << psfb_pkg::IN_LOW_BIT);
                    end
                    psfb_pkg::CMD_TEMP_STATUS: begin
                        rd_data_r <= tmp_flags[host_req.page];
                    end
                    psfb_pkg::CMD_CML_STATUS: begin
                        rd_data_r <= cml_flags[host_req.page];
                    end
                    default: begin
                        rd_data_r <= 8'h00;
                    end
                endcase
            end
        end
    end
endmodule

/* psfb_pkg.sv */
// package: command codes, field positions, reset values and carrier types of the status flag bank
package psfb_pkg;
    localparam int          NUM_PAGES        = 2;
    localparam logic [7:0]  CMD_INPUT_STATUS = 8'h7c;
    localparam logic [7:0]  CMD_TEMP_STATUS  = 8'h7d;
    localparam logic [7:0]  CMD_CML_STATUS   = 8'h7e;
    // input voltage status fields
    localparam int          IN_OVF_BIT       = 7;
    localparam int          IN_UVW_BIT       = 5;
    localparam int          IN_LOW_BIT       = 3;
    // temperature status fields
    localparam int          TMP_OTF_BIT      = 7;
    localparam int          TMP_OTW_BIT      = 6;
    // communication status fields
    localparam int          CML_CMD_BIT      = 7;
    localparam int          CML_DATA_BIT     = 6;
    localparam int          CML_PEC_BIT      = 5;
    localparam int          CML_MEM_BIT      = 4;
    localparam int          CML_CORE_BIT     = 3;
    localparam int          CML_LINK_BIT     = 1;
    // supported bit masks; every other position reads zero, except the live low-input bit 3 of input status
    localparam logic [7:0]  IN_LATCH_MASK    = 8'ha0;
    localparam logic [7:0]  TMP_LATCH_MASK   = 8'hc0;
    localparam logic [7:0]  CML_LATCH_MASK   = 8'hfa;
    localparam logic [7:0]  FLAG_RESET       = 8'h00;
    localparam logic        LOW_IN_RESET     = 1'b1;

    // per-page fault events, one-cycle pulses from same-clock logic
    typedef struct packed {
        logic input_overvolt_fault;
        logic input_undervolt_warn;
        logic overtemp_fault;
        logic overtemp_warn;
        logic bad_command_flag;
        logic bad_payload_flag;
        logic pec_fail;
        logic memory_error;
        logic logic_core_error;
        logic link_error_flag;
        logic backchannel_fault;
    } psfb_events_s;

    // host transaction from the bus engine
    typedef struct packed {
        logic       wr_valid;
        logic       rd_valid;
        logic       clear_faults;
        logic [7:0] command;
        logic [7:0] data;
        logic [0:0] page;
    } psfb_host_req_s;

    // alert mask bits for the alertable flags of one page
    typedef struct packed {
        logic [7:0] input_mask;
        logic [7:0] temp_mask;
        logic [7:0] cml_mask;
    } psfb_mask_s;
endpackage

/* psfb_flag_byte.sv */
// one latched status byte: set by events, cleared by clear-faults or write-one
module psfb_flag_byte #(
    parameter logic [7:0] LATCH_MASK = 8'h00
) (
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] set_bits,
    input  wire logic       clear_all,
    input  wire logic       write_one,
    input  wire logic [7:0] write_data,
    output      logic [7:0] flags_r
);
    logic [7:0] clr;
    logic [7:0] flags_nxt;

    always_comb begin
        clr = clear_all ? 8'hff : (write_one ? write_data : 8'h00);
        // a set arriving with its clear wins, so no event is lost
        flags_nxt = ((flags_r & ~clr) | set_bits) & LATCH_MASK;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_r <= psfb_pkg::FLAG_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end
endmodule

/* psfb_status_bank_sva.sv */
// checker: read timing, field padding, summary and alert relations at the bank ports
module psfb_status_bank_sva (
    input wire logic                         sys_clk,
    input wire logic                         reset_n,
    input wire psfb_pkg::psfb_host_req_s     host_req,
    input wire psfb_pkg::psfb_events_s [1:0] events,
    input wire psfb_pkg::psfb_mask_s [1:0]   alert_masks,
    input wire logic [7:0]                   rd_data_r,
    input wire logic                         rd_valid_r,
    input wire logic                         bad_command_r,
    input wire logic [1:0]                   cml_summary_r,
    input wire logic [1:0]                   alert_request_r
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic [7:0] cmd   = host_req.command;
    wire logic       known = cmd inside {8'h7c, 8'h7d, 8'h7e};
    wire logic       acc   = host_req.rd_valid | host_req.wr_valid;
    // a clear in the following cycle may legally wipe a fresh flag
    wire logic       quiet = !(host_req.clear_faults | host_req.wr_valid);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    rd_answer_a: assert property (host_req.rd_valid |=> rd_valid_r)
        else $error("read not answered next cycle");
    bad_cmd_a: assert property (acc && !known |=> bad_command_r)
        else $error("unknown command not flagged");
    bad_read_a: assert property (host_req.rd_valid && !known |=> rd_data_r == 8'h00)
        else $error("unknown command read not zero");
    in_pad_a: assert property (host_req.rd_valid && cmd == 8'h7c |=>
        (rd_data_r & 8'h57) == 8'h00)
        else $error("input status padding not zero");
    tmp_pad_a: assert property (host_req.rd_valid && cmd == 8'h7d |=>
        rd_data_r[5:0] == 6'h00)
        else $error("temperature padding not zero");
    cml_pad_a: assert property (host_req.rd_valid && cmd == 8'h7e |=>
        !rd_data_r[2] && !rd_data_r[0])
        else $error("communication padding not zero");
    summary_set_a: assert property (events[0].bad_payload_flag ##1 quiet |=> cml_summary_r[0])
        else $error("summary bit not raised");
    alert_set_a: assert property (events[0].overtemp_fault && !alert_masks[0].temp_mask[7]
        ##1 quiet |=> alert_request_r[0])
        else $error("unmasked alert not raised");
endmodule
bind psfb_status_bank psfb_status_bank_sva i_sva (
    .sys_clk(sys_clk), .reset_n(reset_n), .host_req(host_req), .events(events),
    .alert_masks(alert_masks), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .bad_command_r(bad_command_r), .cml_summary_r(cml_summary_r),
    .alert_request_r(alert_request_r)
);

/* psfb_host_model.sv */
// host model: issues one bus-engine request at a time
module psfb_host_model (
    input  wire logic                     sys_clk,
    output      psfb_pkg::psfb_host_req_s host_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial host_req = '0;
    // kind is {write, read, clear}; idle qualifiers are zero and idle payload fields show inverted junk, not stale values
    task automatic xfer(input logic [2:0] kind, input logic [7:0] cmd, dat, input logic pg);
        @(posedge sys_clk) #1;
        host_req = {kind, cmd, dat, pg};
        @(posedge sys_clk) #1;
        host_req = {3'h0, ~cmd, ~dat, ~pg};
    endtask
endmodule

/* tb_pmbus_status_flag_bank.sv */
// testbench: status flag bank reads, clears, events and alerts
module tb_pmbus_status_flag_bank;
    timeunit 1ns;
    timeprecision 100ps;
    logic                         sys_clk = 1'b0;
    logic                         reset_n = 1'b0;
    psfb_pkg::psfb_host_req_s     host_req;
    psfb_pkg::psfb_events_s [1:0] events = '0;
    psfb_pkg::psfb_mask_s [1:0]   alert_masks = '0;
    logic [1:0]                   rail_low = 2'h3;
    logic [1:0]                   five_low = 2'h0;
    logic [1:0]                   follower = 2'h1;
    logic [7:0]                   rd_data_r;
    logic                         rd_valid_r;
    logic                         bad_command_r;
    logic [1:0]                   cml_summary_r;
    logic [1:0]                   alert_request_r;
    int                           failures = 0;
    int                           total_checks = 0;
    always #10 sys_clk = ~sys_clk;
    psfb_host_model i_host (
        .sys_clk  (sys_clk),
        .host_req (host_req)
    );
    psfb_status_bank i_dut (
        .sys_clk                     (sys_clk),
        .reset_n                     (reset_n),
        .host_req                    (host_req),
        .events                      (events),
        .alert_masks                 (alert_masks),
        .power_input_rail_low        (rail_low),
        .internal_five_volt_rail_low (five_low),
        .is_loop_follower            (follower),
        .rd_data_r                   (rd_data_r),
        .rd_valid_r                  (rd_valid_r),
        .bad_command_r               (bad_command_r),
        .cml_summary_r               (cml_summary_r),
        .alert_request_r             (alert_request_r)
    );
    task automatic chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // bounded wait: the answer is due one cycle after the read is taken
    task automatic rd(input logic [7:0] cmd, input logic pg, input logic [7:0] exp);
        int n;
        i_host.xfer(3'h2, cmd, 8'h00, pg);
        for (n = 0; n < 4 && rd_valid_r !== 1'b1; n++) @(posedge sys_clk) #1;
        if (n == 4) begin
            failures++;
            stop_test();
        end
        chk(rd_data_r, exp);
    endtask
    task automatic wr(input logic [7:0] cmd, input logic pg, input logic [7:0] dat);
        i_host.xfer(3'h4, cmd, dat, pg);
    endtask
    task automatic ev(input logic pg, input psfb_pkg::psfb_events_s e);
        @(posedge sys_clk) #1;
        events[pg] = e;
        @(posedge sys_clk) #1;
        events[pg] = '0;
    endtask
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        stop_test();
    end
    initial begin
        cyc(20);
        reset_n = 1'b1;
        rd(8'h7c, 1'h0, 8'h08);
        rd(8'h7d, 1'h0, 8'h00);
        rd(8'h7e, 1'h1, 8'h00);
        chk({6'h00, alert_request_r}, 8'h00);
        $display("reset values done");
        rail_low[0] = 1'b0;
        cyc(4);
        rd(8'h7c, 1'h0, 8'h00);
        rd(8'h7c, 1'h1, 8'h08);
        five_low[0] = 1'b1;
        cyc(4);
        rd(8'h7c, 1'h0, 8'h08);
        five_low[0] = 1'b0;
        $display("live input bit done");
        ev(1'h0, 11'h7ff);
        ev(1'h1, 11'h200);
        cyc(2);
        chk({6'h00, cml_summary_r}, 8'h01);
        chk({6'h00, alert_request_r}, 8'h01);
        rd(8'h7c, 1'h0, 8'ha0);
        rd(8'h7d, 1'h0, 8'hc0);
        rd(8'h7e, 1'h0, 8'hfa);
        rd(8'h7c, 1'h1, 8'h08);
        $display("event latching done");
        wr(8'h7e, 1'h0, 8'h80);
        rd(8'h7e, 1'h0, 8'h7a);
        wr(8'h7e, 1'h0, 8'hff);
        rd(8'h7e, 1'h0, 8'h00);
        chk({6'h00, cml_summary_r}, 8'h00);
        wr(8'h7c, 1'h0, 8'h28);
        rd(8'h7c, 1'h0, 8'h80);
        i_host.xfer(3'h1, 8'h7e, 8'h00, 1'h0);
        wr(8'h7d, 1'h0, 8'h3f);
        rd(8'h7c, 1'h0, 8'h00);
        rd(8'h7d, 1'h0, 8'h00);
        chk({6'h00, alert_request_r}, 8'h00);
        $display("clearing done");
        alert_masks[0].temp_mask = 8'h80;
        ev(1'h0, 11'h100);
        cyc(2);
        chk({6'h00, alert_request_r}, 8'h00);
        rd(8'h7d, 1'h0, 8'h80);
        chk({7'h00, bad_command_r}, 8'h00);
        rd(8'h7f, 1'h0, 8'h00);
        chk({7'h00, bad_command_r}, 8'h01);
        ev(1'h0, 11'h001);
        ev(1'h1, 11'h001);
        rd(8'h7e, 1'h0, 8'h82);
        rd(8'h7e, 1'h1, 8'h00);
        $display("mask and command errors done");
        stop_test();
    end
endmodule
